//--- design/gpio_mux_pkg.sv
/*
 * constants for the shared-pin mux and port a/b/c block: register
 * addresses in data space, field positions, reset values, clock-out codes.
 * assumes a 16-bit data-memory bus from the cpu, all on mclk.
 */
package gpio_mux_pkg;
  localparam logic [15:0] ADDR_MUX_A = 16'h7090;
  localparam logic [15:0] ADDR_MUX_B = 16'h7092;
  localparam logic [15:0] ADDR_PORT_A = 16'h7098;
  localparam logic [15:0] ADDR_PORT_B = 16'h709a;
  localparam logic [15:0] ADDR_PORT_C = 16'h709c;

  // data in the low byte, direction in the high byte
  localparam int DATA_LSB = 0;
  localparam int DIR_LSB = 8;
  localparam int PORT_A_BITS = 4;
  localparam int PORT_BITS = 8;
  // mux control register a: port a at bit 0, port b at bit 8
  localparam int MUX_A_PORT_A_LSB = 0;
  localparam int MUX_A_PORT_B_LSB = 8;

  // port c bits whose mux bit selects the port when 1
  localparam logic [7:0] PORT_C_INVERTED = 8'h0c;
  localparam int PORT_C_CLKOUT_BIT = 1;

  localparam logic [15:0] MUX_A_RESET = 16'h0000;
  localparam logic [15:0] MUX_B_RESET = 16'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;

  typedef enum logic [1:0] {
    CLKOUT_PORT = 2'b00,
    CLKOUT_WATCHDOG = 2'b01,
    CLKOUT_SYSTEM = 2'b10,
    CLKOUT_CPU = 2'b11
  } clkout_sel_t;
endpackage

//--- design/shared_pin_cell.sv
/*
 * one shared pin: picks port or peripheral drive, registers the pin
 * drive, and brings the pin level in through two flip-flops.
 * assumes port_sel, dir, dat and periph_* are on mclk; pin_in is async.
 */
module shared_pin_cell (
  input wire logic mclk,
  input wire logic rst_s_n,
  input wire logic ce,
  input wire logic port_sel,
  input wire logic dir,
  input wire logic dat,
  input wire logic periph_out,
  input wire logic periph_oe,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_sync
);
  logic out_ff, oe_ff, meta_ff, sync_ff;
  logic nxt_out, nxt_oe, nxt_meta, nxt_sync;

  // port mode uses dir/dat, otherwise the peripheral owns the pin
  always_comb begin
    nxt_out = out_ff;
    nxt_oe = oe_ff;
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (ce) begin
      if (port_sel) begin
        nxt_oe = dir;
        nxt_out = dir & dat;
      end else begin
        nxt_oe = periph_oe;
        nxt_out = periph_out;
      end
      nxt_meta = pin_in;
      nxt_sync = meta_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign pin_sync = sync_ff;

  a_port_drive: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && port_sel && dir |=> pin_oe && pin_out == $past(dat))
    else $error("port output not driven from data bit");
  a_port_input: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && port_sel && !dir |=> !pin_oe && !pin_out)
    else $error("port input pin still driven");
  // the flops still see reset at the edge where rst_s_n rises, so skip that edge
  a_periph_pass: assert property (@(posedge mclk) disable iff (!rst_s_n)
    rst_s_n && ce && !port_sel
    |=> pin_out == $past(periph_out) && pin_oe == $past(periph_oe))
    else $error("peripheral drive not passed to pin");
  a_sync_two_ff: assert property (@(posedge mclk) disable iff (!rst_s_n)
    (rst_s_n && ce) ##1 ce |=> pin_sync == $past(pin_in, 2))
    else $error("pin level not two stages late");
endmodule

//--- design/shared_pin_mux.sv
/*
 * pin sharing and general-purpose ports a (4 pins), b and c (8 pins each)
 * with their mux control and data/direction registers in data space.
 * assumes the cpu data-memory strobes, system-control clock select and
 * clock sources come from mclk logic; pins arrive asynchronously.
 */
// Contract
// - mux bit 1 peripheral, 0 port
// - direction 0 input, 1 output
// - read returns pin, write drives pin (output pins read back the data latch, not the pin)
// - data/direction ignored while peripheral selected
// - port a mux and register layout
// - port b mux and register layout
// - port c bit 0 start-input mux
// - two-bit field picks port or clock
// - port c bits 2,3 inverted mux
// - port c bits 4-7 capture mux
// - registers sit in data space
// - register addresses 7090h to 709ch
module shared_pin_mux
  import gpio_mux_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] dm_addr,
  input wire logic [15:0] dm_wdata,
  input wire logic dm_we,
  input wire logic dm_re,
  output logic [15:0] dm_rdata,
  input wire logic [1:0] clkout_sel,
  input wire logic watchdog_clock,
  input wire logic system_clock_out,
  input wire logic cpu_clock_out,
  input wire logic external_flag_output,
  input wire logic [7:0] pb_periph_out,
  input wire logic [7:0] pb_periph_oe,
  input wire logic [7:0] pc_periph_out,
  input wire logic [7:0] pc_periph_oe,
  input wire logic [3:0] pa_pin_in,
  input wire logic [7:0] pb_pin_in,
  input wire logic [7:0] pc_pin_in,
  output logic [3:0] pa_pin_out,
  output logic [3:0] pa_pin_oe,
  output logic [7:0] pb_pin_out,
  output logic [7:0] pb_pin_oe,
  output logic [7:0] pc_pin_out,
  output logic [7:0] pc_pin_oe,
  output logic [3:0] pa_periph_in,
  output logic [7:0] pb_periph_in,
  output logic [7:0] pc_periph_in
);
  localparam int NPIN = PORT_A_BITS + 2 * PORT_BITS;

  logic [1:0] rst_sync_ff;
  logic rst_s_n;
  logic [15:0] pin_mux_control_a_ff, nxt_pin_mux_control_a;
  logic [15:0] pin_mux_control_b_ff, nxt_pin_mux_control_b;
  logic [3:0] pa_dat_ff, nxt_pa_dat, pa_dir_ff, nxt_pa_dir;
  logic [7:0] pb_dat_ff, nxt_pb_dat, pb_dir_ff, nxt_pb_dir;
  logic [7:0] pc_dat_ff, nxt_pc_dat, pc_dir_ff, nxt_pc_dir;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [7:0] pc_port_sel, pc_drv_out, pc_drv_oe;
  logic [NPIN-1:0] port_sel, dir_v, dat_v, p_out, p_oe, pin_in_v, pin_out_v, pin_oe_v, sync_v;
  logic clk_src;

  // reset is released through two flops; assertion is immediate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_ff[1];

  // register writes from the cpu data-memory bus
  always_comb begin
    nxt_pin_mux_control_a = pin_mux_control_a_ff;
    nxt_pin_mux_control_b = pin_mux_control_b_ff;
    nxt_pa_dat = pa_dat_ff;
    nxt_pa_dir = pa_dir_ff;
    nxt_pb_dat = pb_dat_ff;
    nxt_pb_dir = pb_dir_ff;
    nxt_pc_dat = pc_dat_ff;
    nxt_pc_dir = pc_dir_ff;
    if (ce && dm_we) begin
      case (dm_addr)
        ADDR_MUX_A: nxt_pin_mux_control_a = dm_wdata;
        ADDR_MUX_B: nxt_pin_mux_control_b = dm_wdata;
        ADDR_PORT_A: begin
          nxt_pa_dat = dm_wdata[DATA_LSB +: PORT_A_BITS];
          nxt_pa_dir = dm_wdata[DIR_LSB +: PORT_A_BITS];
        end
        ADDR_PORT_B: begin
          nxt_pb_dat = dm_wdata[DATA_LSB +: PORT_BITS];
          nxt_pb_dir = dm_wdata[DIR_LSB +: PORT_BITS];
        end
        ADDR_PORT_C: begin
          nxt_pc_dat = dm_wdata[DATA_LSB +: PORT_BITS];
          nxt_pc_dir = dm_wdata[DIR_LSB +: PORT_BITS];
        end
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // reads: output pins give the latch, input pins the synced level
  always_comb begin
    nxt_rdata = rdata_ff;
    if (ce && dm_re) begin
      case (dm_addr)
        ADDR_MUX_A: nxt_rdata = pin_mux_control_a_ff;
        ADDR_MUX_B: nxt_rdata = pin_mux_control_b_ff;
        ADDR_PORT_A: nxt_rdata = {4'h0, pa_dir_ff, 4'h0,
          (pa_dir_ff & pa_dat_ff) | (~pa_dir_ff & sync_v[3:0])};
        ADDR_PORT_B: nxt_rdata = {pb_dir_ff,
          (pb_dir_ff & pb_dat_ff) | (~pb_dir_ff & sync_v[11:4])};
        ADDR_PORT_C: nxt_rdata = {pc_dir_ff,
          (pc_dir_ff & pc_dat_ff) | (~pc_dir_ff & sync_v[19:12])};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pin_mux_control_a_ff <= MUX_A_RESET;
      pin_mux_control_b_ff <= MUX_B_RESET;
      pa_dat_ff <= DATA_RESET[3:0];
      pa_dir_ff <= DIR_RESET[3:0];
      pb_dat_ff <= DATA_RESET;
      pb_dir_ff <= DIR_RESET;
      pc_dat_ff <= DATA_RESET;
      pc_dir_ff <= DIR_RESET;
      rdata_ff <= 16'h0000;
    end else begin
      pin_mux_control_a_ff <= nxt_pin_mux_control_a;
      pin_mux_control_b_ff <= nxt_pin_mux_control_b;
      pa_dat_ff <= nxt_pa_dat;
      pa_dir_ff <= nxt_pa_dir;
      pb_dat_ff <= nxt_pb_dat;
      pb_dir_ff <= nxt_pb_dir;
      pc_dat_ff <= nxt_pc_dat;
      pc_dir_ff <= nxt_pc_dir;
      rdata_ff <= nxt_rdata;
    end
  end
  assign dm_rdata = rdata_ff;

  // port c selection: bits 2,3 inverted, bit 1 from the clock-out field
  always_comb begin
    pc_port_sel = ~pin_mux_control_b_ff[7:0] ^ PORT_C_INVERTED;
    pc_port_sel[PORT_C_CLKOUT_BIT] = (clkout_sel == CLKOUT_PORT);
    pc_drv_out = pc_periph_out;
    pc_drv_oe = pc_periph_oe;
    pc_drv_out[2] = external_flag_output;
    pc_drv_oe[2] = 1'b1;
    pc_drv_oe[3] = 1'b0; // branch-control is an input only
    case (clkout_sel)
      CLKOUT_WATCHDOG: clk_src = watchdog_clock;
      CLKOUT_SYSTEM: clk_src = system_clock_out;
      CLKOUT_CPU: clk_src = cpu_clock_out;
      default: clk_src = 1'b0;
    endcase
    pc_drv_out[PORT_C_CLKOUT_BIT] = clk_src;
    pc_drv_oe[PORT_C_CLKOUT_BIT] = 1'b1;
  end

  // flatten the three ports; analogue inputs never drive their pins
  assign port_sel = {pc_port_sel,
    ~pin_mux_control_a_ff[MUX_A_PORT_B_LSB +: PORT_BITS],
    ~pin_mux_control_a_ff[MUX_A_PORT_A_LSB +: PORT_A_BITS]};
  assign dir_v = {pc_dir_ff, pb_dir_ff, pa_dir_ff};
  assign dat_v = {pc_dat_ff, pb_dat_ff, pa_dat_ff};
  assign p_out = {pc_drv_out, pb_periph_out, 4'h0};
  assign p_oe = {pc_drv_oe, pb_periph_oe, 4'h0};
  assign pin_in_v = {pc_pin_in, pb_pin_in, pa_pin_in};

  // one cell per shared pin
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    shared_pin_cell u_cell (
      .mclk(mclk),
      .rst_s_n(rst_s_n),
      .ce(ce),
      .port_sel(port_sel[i]),
      .dir(dir_v[i]),
      .dat(dat_v[i]),
      .periph_out(p_out[i]),
      .periph_oe(p_oe[i]),
      .pin_in(pin_in_v[i]),
      .pin_out(pin_out_v[i]),
      .pin_oe(pin_oe_v[i]),
      .pin_sync(sync_v[i])
    );
  end

  assign pa_pin_out = pin_out_v[3:0];
  assign pa_pin_oe = pin_oe_v[3:0];
  assign pb_pin_out = pin_out_v[11:4];
  assign pb_pin_oe = pin_oe_v[11:4];
  assign pc_pin_out = pin_out_v[19:12];
  assign pc_pin_oe = pin_oe_v[19:12];
  assign pa_periph_in = sync_v[3:0];
  assign pb_periph_in = sync_v[11:4];
  assign pc_periph_in = sync_v[19:12];

  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && dm_re && dm_addr != ADDR_MUX_A && dm_addr != ADDR_MUX_B
    && dm_addr != ADDR_PORT_A && dm_addr != ADDR_PORT_B && dm_addr != ADDR_PORT_C
    |=> dm_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_mux_a_write: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && dm_we && dm_addr == ADDR_MUX_A ##1 ce && dm_re && dm_addr == ADDR_MUX_A
    |=> dm_rdata == $past(dm_wdata, 2))
    else $error("mux control a does not read back");
  a_read_input: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && dm_re && dm_addr == ADDR_PORT_A && !pa_dir_ff[0]
    |=> dm_rdata[0] == $past(sync_v[0]) && dm_rdata[8] == 1'b0)
    else $error("input pin level not returned");
  // the cells leave reset one edge after rst_s_n, so the release edge is skipped
  a_clkout_cpu: assert property (@(posedge mclk) disable iff (!rst_s_n)
    rst_s_n && ce && clkout_sel == CLKOUT_CPU
    |=> pc_pin_oe[1] && pc_pin_out[1] == $past(cpu_clock_out))
    else $error("cpu clock not on clock-out pin");
  a_inverted_mux: assert property (@(posedge mclk) disable iff (!rst_s_n)
    rst_s_n && ce && !pin_mux_control_b_ff[2]
    |=> pc_pin_oe[2] && pc_pin_out[2] == $past(external_flag_output))
    else $error("flag output not on pin when mux bit 0");
  a_port_b_periph: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && pin_mux_control_a_ff[8] |=> pb_pin_out[0] == $past(pb_periph_out[0]))
    else $error("compare output not on port b pin 0");
endmodule

//--- tb/pin_world.sv
/*
 * board side of one port: an outside source drives every pin whose
 * output enable is low. assumes one bit of each vector per pin.
 */
module pin_world #(
  parameter int W = 8
) (
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] lvl,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // driven pins follow the device, released pins follow the outside
  // source, so a released pin never shows a stale device level
  assign pin = (oe & drv) | (~oe & lvl);
endmodule

//--- tb/tb.sv
/*
 * scenarios for shared_pin_mux over its data-space strobes.
 * assumes pin_world closes the pins; ce is high except in the freeze scenario.
 */
module tb
  import gpio_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, ce, dm_we, dm_re, wd_clk, sys_clk, cpu_clk, flag;
  logic [1:0] clkout_sel;
  logic [15:0] dm_addr, dm_wdata, dm_rdata;
  logic [7:0] pb_po, pb_poe, pc_po, pc_poe, pb_in, pc_in, pb_out, pb_oe, pc_out, pc_oe;
  logic [7:0] pb_pi, pc_pi, pb_lvl, pc_lvl;
  logic [3:0] pa_in, pa_out, pa_oe, pa_pi, pa_lvl;
  int fails, checks_done;

  shared_pin_mux i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
    .clkout_sel(clkout_sel), .watchdog_clock(wd_clk), .system_clock_out(sys_clk),
    .cpu_clock_out(cpu_clk), .external_flag_output(flag), .pb_periph_out(pb_po),
    .pb_periph_oe(pb_poe), .pc_periph_out(pc_po), .pc_periph_oe(pc_poe),
    .pa_pin_in(pa_in), .pb_pin_in(pb_in), .pc_pin_in(pc_in), .pa_pin_out(pa_out),
    .pa_pin_oe(pa_oe), .pb_pin_out(pb_out), .pb_pin_oe(pb_oe), .pc_pin_out(pc_out),
    .pc_pin_oe(pc_oe), .pa_periph_in(pa_pi), .pb_periph_in(pb_pi), .pc_periph_in(pc_pi));
  pin_world #(.W(4)) i_pa (.drv(pa_out), .oe(pa_oe), .lvl(pa_lvl), .pin(pa_in));
  pin_world #(.W(8)) i_pb (.drv(pb_out), .oe(pb_oe), .lvl(pb_lvl), .pin(pb_in));
  pin_world #(.W(8)) i_pc (.drv(pc_out), .oe(pc_oe), .lvl(pc_lvl), .pin(pc_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // strobes rise just after an edge and are taken at the next one
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    cyc(1);
    dm_addr = a;
    dm_wdata = d;
    dm_we = 1'b1;
    cyc(1);
    dm_we = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    cyc(1);
    dm_addr = a;
    dm_re = 1'b1;
    cyc(1);
    dm_re = 1'b0;
    chk(dm_rdata, exp, "read data");
  endtask

  task automatic t_reset();
    rd(ADDR_MUX_A, 16'h0000);
    rd(ADDR_MUX_B, 16'h0000);
    rd(ADDR_PORT_A, 16'h0000);
    rd(ADDR_PORT_B, 16'h0000);
    rd(ADDR_PORT_C, 16'h0000);
    rd(16'h7094, 16'h0000);
    chk(16'(pc_oe), 16'h0004, "reset pin enables");
  endtask

  // unused port a bits are dropped; then the pins turn into inputs
  task automatic t_port_a();
    wr(ADDR_PORT_A, 16'hfff5);
    cyc(1);
    chk(16'({pa_oe, pa_out}), 16'h00f5, "port a drive");
    rd(ADDR_PORT_A, 16'h0f05);
    wr(ADDR_PORT_A, 16'h0000);
    pa_lvl = 4'ha;
    cyc(3);
    chk(16'(pa_pi), 16'h000a, "port a synced pins");
    rd(ADDR_PORT_A, 16'h000a);
  endtask

  task automatic t_primary_b();
    pb_po = 8'ha5;
    pb_poe = 8'h0f;
    wr(ADDR_PORT_B, 16'hff3c);
    wr(ADDR_MUX_A, 16'hff00);
    cyc(1);
    chk({pb_oe, pb_out}, 16'h0fa5, "port b primary");
    wr(ADDR_MUX_A, 16'h0000);
    cyc(1);
    chk({pb_oe, pb_out}, 16'hff3c, "port b port mode");
  endtask

  // bit 0 primary, bits 2 and 3 handed to the port by a set mux bit
  task automatic t_port_c();
    pc_po = 8'h01;
    pc_poe = 8'h01;
    flag = 1'b1;
    cyc(2);
    chk(16'(pc_out[2]), 16'h0001, "flag on pin c2");
    wr(ADDR_PORT_C, 16'hff0a);
    wr(ADDR_MUX_B, 16'h000d);
    cyc(1);
    chk({pc_oe, pc_out}, 16'hff0b, "port c mix");
  endtask

  // each clock code (1 to 3) once with its own source high, then with it low
  task automatic t_clkout();
    for (int i = 1; i < 4; i++) begin
      {cpu_clk, sys_clk, wd_clk} = 3'b001 << (i - 1);
      clkout_sel = 2'(i);
      cyc(2);
      chk(16'({pc_oe[1], pc_out[1]}), 16'h0003, "clock out high");
      {cpu_clk, sys_clk, wd_clk} = ~(3'b001 << (i - 1));
      cyc(2);
      chk(16'({pc_oe[1], pc_out[1]}), 16'h0002, "clock out low");
    end
    clkout_sel = 2'b00;
    cyc(2);
    chk(16'(pc_out[1]), 16'h0001, "port c1 back");
  endtask

  // write then read next cycle, then both strobes in one cycle (read sees old)
  task automatic t_bus_order();
    cyc(1);
    dm_addr = ADDR_MUX_A;
    dm_wdata = 16'h5a0f;
    dm_we = 1'b1;
    cyc(1);
    dm_we = 1'b0;
    dm_re = 1'b1;
    cyc(1);
    chk(dm_rdata, 16'h5a0f, "read right after write");
    dm_wdata = 16'h0000;
    dm_we = 1'b1;
    cyc(1);
    dm_we = 1'b0;
    dm_re = 1'b0;
    chk(dm_rdata, 16'h5a0f, "read beside write sees old");
    rd(16'h7096, 16'h0000);
    rd(ADDR_MUX_A, 16'h0000);
  endtask

  // ce low: a write is not taken and the pins hold their drive
  task automatic t_freeze();
    cyc(1);
    ce = 1'b0;
    dm_addr = ADDR_PORT_B;
    dm_wdata = 16'hffc3;
    dm_we = 1'b1;
    cyc(2);
    dm_we = 1'b0;
    ce = 1'b1;
    chk({pb_oe, pb_out}, 16'hff3c, "pins frozen while ce low");
    rd(ADDR_PORT_B, 16'hff3c);
  endtask

  // ports b and c turned to inputs; c0 stays primary and driven high
  task automatic t_pin_inputs();
    wr(ADDR_PORT_B, 16'h0000);
    wr(ADDR_PORT_C, 16'h0000);
    pb_lvl = 8'h96;
    pc_lvl = 8'h5a;
    cyc(3);
    chk(16'(pb_pi), 16'h0096, "port b synced pins");
    chk(16'(pc_pi), 16'h005b, "port c synced pins");
    rd(ADDR_PORT_B, 16'h0096);
    rd(ADDR_PORT_C, 16'h005b);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200us;
    fails++;
    wrap_up();
  end

  initial begin
    {rst_n, dm_we, dm_re, wd_clk, sys_clk, cpu_clk, flag} = 7'h00;
    ce = 1'b1;
    {clkout_sel, dm_addr, dm_wdata} = 34'h0;
    {pb_po, pb_poe, pc_po, pc_poe, pb_lvl, pc_lvl, pa_lvl} = 52'h0;
    fails = 0;
    checks_done = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_port_a();
    t_primary_b();
    t_port_c();
    t_clkout();
    t_bus_order();
    t_freeze();
    t_pin_inputs();
    wrap_up();
  end
endmodule
